// ==== phy_reset_and_strap_latch.sv ====
// phy reset sequencing and configuration strap latching behind an ahb-lite slave
//
// Contract
// - port1 reset from either request bit or from power-down exit
// - completion clears both port1 reset bits
// - power-down exit resets phy, registers kept
// - port1 reset bits clear after 110us
// - basic-control reset keeps sticky bits
// - emulated phy reset from either bit
// - emulated reset bits clear after 1us
// - hard and soft straps latched at reset
// - eeprom overrides soft straps, never hard
// - soft straps captured, then eeprom replaces
// - pinless soft straps take tie-off defaults
// - straps load or steer register bits
// - digital reset or reload reverts soft straps
// - pins never resampled except on reset
// - led enable straps default ones, load enables
// - led function strap default zero, loads field
// - auto-mdix strap loads state, steers mdix
// - manual strap picks mdi or crossover
// - autoneg strap default one, loads enable
`timescale 1ns/10ps
`include "phy_reset_defs.svh"

module phy_reset_and_strap_latch
  import phy_reset_pkg::*;
#(
  parameter int PORT1_PHY_RESET_REQ_CYCLES = `PORT1_PHY_RESET_REQ_TIME_NS / `CLK_PERIOD_NS,
  parameter int EMU_RST_CYCLES = `EMU_RST_TIME_NS / `CLK_PERIOD_NS
) (
  input wire logic CLOCK,
  input wire logic EXTERNAL_RESET_PIN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic STRAP_AUTO_MDIX,
  input wire logic STRAP_MANUAL_MDIX,
  input wire logic STRAP_HARD,
  input wire logic EE_PRESENT,
  input wire logic EE_LOAD,
  input wire logic [5:0] EE_LED_EN,
  input wire logic [1:0] EE_LED_FUN,
  input wire logic EE_AUTO_MDIX,
  input wire logic EE_MANUAL_MDIX,
  input wire logic EE_AUTONEG,
  output logic PHY1_RESET,
  output logic EMU_PHY_RESET,
  output logic PHY1_POWER_DOWN,
  output logic PHY1_AN_EN,
  output logic PHY1_SPEED_LSB,
  output logic PHY1_DUPLEX,
  output logic MDIX_AUTO,
  output logic MDIX_CROSS,
  output logic [5:0] LED_EN,
  output logic [1:0] LED_FUN,
  output logic DIGITAL_RESET,
  output logic EE_RELOAD
);

  localparam int CW = 12;

  // counters are 12 bits wide; longer counts need a wider counter
  if (PORT1_PHY_RESET_REQ_CYCLES < 1 || PORT1_PHY_RESET_REQ_CYCLES >= (1 << CW)) begin : g_chk_phy1
    $error("PORT1_PHY_RESET_REQ_CYCLES out of range");
  end
  if (EMU_RST_CYCLES < 1 || EMU_RST_CYCLES >= (1 << CW)) begin : g_chk_emu
    $error("EMU_RST_CYCLES out of range");
  end

  localparam logic [CW-1:0] PHY1_LAST = CW'(PORT1_PHY_RESET_REQ_CYCLES - 1);
  localparam logic [CW-1:0] EMU_LAST = CW'(EMU_RST_CYCLES - 1);

  // bus address and data phase
  logic dp_write;
  logic [7:0] dp_addr;
  wire addr_phase = HSEL & HTRANS[1] & HREADY;

  // strap synchronisers and capture
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [1:0] settle;
  logic latched;
  logic lat_auto;
  logic lat_manual;
  logic lat_hard;
  logic [5:0] soft_led_en;
  logic [1:0] soft_led_fun;
  logic soft_auto;
  logic soft_manual;
  logic soft_an;
  logic strap_update;

  // software visible state
  logic [14:0] phy_bc;
  logic [14:0] emu_bc;
  logic [5:0] led_en;
  logic [1:0] led_fun;
  logic [2:0] phy_special;

  // reset sequencers
  seq_state_t phy1_state;
  seq_state_t emu_state;
  logic [CW-1:0] phy1_cnt;
  logic [CW-1:0] emu_cnt;

  wire phy1_busy = (phy1_state == SEQ_BUSY);
  wire emu_busy = (emu_state == SEQ_BUSY);

  // write decode, data phase
  wire wr_rc = dp_write & (dp_addr == `A_RESET_CTRL);
  wire wr_bc = dp_write & (dp_addr == `A_PHY_BASIC);
  wire wr_emu = dp_write & (dp_addr == `A_EMU_BASIC);
  wire wr_led = dp_write & (dp_addr == `A_LED_CONFIG_REG);
  wire wr_ee = dp_write & (dp_addr == `A_EE_CMD);
  wire wr_sc = dp_write & (dp_addr == `A_PHY_SPECIAL);

  // ones start resets; a zero starts one only when it clears a set power-down bit
  wire start_rc = wr_rc & HWDATA[`RC_PHY1];
  wire start_bc = wr_bc & HWDATA[`BC_RESET];
  wire start_pd = wr_bc & phy_bc[`BC_PDOWN] & ~HWDATA[`BC_PDOWN];
  wire phy1_go = ~phy1_busy & (start_rc | start_bc | start_pd);
  wire emu_go = ~emu_busy & ((wr_rc & HWDATA[`RC_EMU]) | (wr_emu & HWDATA[`BC_RESET]));

  // a reset-control request reinitialises the whole basic control register, a basic-control one keeps sticky bits
  wire rst_kind_t kind = start_rc ? RK_FULL : start_bc ? RK_SOFT : RK_KEEP;

  wire dig_go = wr_rc & HWDATA[`RC_DIGITAL];
  wire reload_go = wr_ee & HWDATA[`EE_RELOAD_BIT];
  wire capture = ~latched & (settle == `SYNC_SETTLE);
  wire revert = latched & (dig_go | reload_go);
  wire ee_take = latched & EE_PRESENT & EE_LOAD & ~revert;

  // strap-derived defaults of the basic control register
  // braces keep the inversion one bit wide before the cast widens it
  wire [14:0] strap_bits = (15'(soft_an) << `BC_AN) | (15'h1 << `BC_SPEED)
                         | (15'({~soft_an}) << `BC_DUPLEX);
  wire [14:0] strap_mask = (15'h1 << `BC_AN) | (15'h1 << `BC_SPEED) | (15'h1 << `BC_DUPLEX);
  wire [14:0] bc_default = `PHY_BC_RESET_VAL | strap_bits;
  wire [14:0] bc_soft = (bc_default & ~`PHY_STICKY_MASK) | (phy_bc & `PHY_STICKY_MASK);
  wire [14:0] bc_strapped = (phy_bc & ~strap_mask) | strap_bits;

  wire [14:0] next_phy_bc = (phy1_go && kind == RK_FULL) ? bc_default
                          : (phy1_go && kind == RK_SOFT) ? bc_soft
                          : wr_bc ? HWDATA[14:0]
                          : strap_update ? bc_strapped
                          : phy_bc;

  wire [14:0] next_emu_bc = emu_go ? `EMU_BC_RESET_VAL
                          : wr_emu ? HWDATA[14:0]
                          : emu_bc;

  // mdix selection: strap pair or register pair
  wire strap_sel = phy_special[`SC_STRAP_SEL];
  wire next_mdix_auto = strap_sel ? soft_auto : phy_special[`SC_AUTO];
  wire next_mdix_cross = strap_sel ? (~soft_auto & soft_manual)
                       : (~phy_special[`SC_AUTO] & phy_special[`SC_CROSS]);

  // read mux, address phase
  wire [31:0] rd_rc = (32'(phy1_busy) << `RC_PHY1) | (32'(emu_busy) << `RC_EMU);
  wire [31:0] rd_bc = {16'h0000, phy1_busy, phy_bc};
  wire [31:0] rd_emu = {16'h0000, emu_busy, emu_bc};
  wire [31:0] rd_hw = (32'(latched) << `HW_READY) | (32'(soft_auto) << `HW_AMDIX1)
                    | (32'(lat_hard) << `HW_HARD);
  wire [31:0] rd_led = (32'(led_fun) << `LED_FUN_LSB) | 32'(led_en);
  wire [7:0] ra = HADDR[7:0];
  wire [31:0] rd_mux = (ra == `A_RESET_CTRL) ? rd_rc
                     : (ra == `A_PHY_BASIC) ? rd_bc
                     : (ra == `A_EMU_BASIC) ? rd_emu
                     : (ra == `A_HARDWARE_CONFIG_REG) ? rd_hw
                     : (ra == `A_LED_CONFIG_REG) ? rd_led
                     : (ra == `A_PHY_SPECIAL) ? 32'(phy_special)
                     : 32'h00000000;
  wire rd_now = addr_phase & ~HWRITE;

  // ahb-lite slave: zero wait states, always okay
  always_ff @(posedge CLOCK or negedge EXTERNAL_RESET_PIN) begin
    if (!EXTERNAL_RESET_PIN) begin
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
      HRDATA <= 32'h00000000;
      HREADYOUT <= 1'b0;
      HRESP <= 1'b0;
    end else begin
      dp_write <= addr_phase & HWRITE;
      dp_addr <= HADDR[7:0];
      HRDATA <= rd_now ? rd_mux : 32'h00000000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
  end

  // strap pins pass two flops every cycle; the synchronised values are only used at the capture
  always_ff @(posedge CLOCK or negedge EXTERNAL_RESET_PIN) begin
    if (!EXTERNAL_RESET_PIN) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      settle <= 2'h0;
      latched <= 1'b0;
    end else begin
      sync1 <= {STRAP_HARD, STRAP_MANUAL_MDIX, STRAP_AUTO_MDIX};
      sync2 <= sync1;
      settle <= (settle == `SYNC_SETTLE) ? settle : settle + 2'h1;
      latched <= latched | capture;
    end
  end

  // latched pin values change only on the capture after reset release
  always_ff @(posedge CLOCK or negedge EXTERNAL_RESET_PIN) begin
    if (!EXTERNAL_RESET_PIN) begin
      lat_auto <= 1'b0;
      lat_manual <= 1'b0;
      lat_hard <= 1'b0;
    end else if (capture) begin
      lat_auto <= sync2[0];
      lat_manual <= sync2[1];
      lat_hard <= sync2[2];
    end
  end

  // effective soft straps: capture, revert, then eeprom override
  always_ff @(posedge CLOCK or negedge EXTERNAL_RESET_PIN) begin
    if (!EXTERNAL_RESET_PIN) begin
      soft_led_en <= `LED_EN_DEF;
      soft_led_fun <= `LED_FUN_DEF;
      soft_auto <= 1'b0;
      soft_manual <= 1'b0;
      soft_an <= `AUTONEG_DEF;
    end else if (capture || revert) begin
      soft_led_en <= `LED_EN_DEF;
      soft_led_fun <= `LED_FUN_DEF;
      soft_auto <= capture ? sync2[0] : lat_auto;
      soft_manual <= capture ? sync2[1] : lat_manual;
      soft_an <= `AUTONEG_DEF;
    end else if (ee_take) begin
      soft_led_en <= EE_LED_EN;
      soft_led_fun <= EE_LED_FUN;
      soft_auto <= EE_AUTO_MDIX;
      soft_manual <= EE_MANUAL_MDIX;
      soft_an <= EE_AUTONEG;
    end
  end

  always_ff @(posedge CLOCK or negedge EXTERNAL_RESET_PIN) begin
    if (!EXTERNAL_RESET_PIN) begin
      strap_update <= 1'b0;
    end else begin
      strap_update <= capture | revert | ee_take;
    end
  end

  // led configuration: straps load it, software may rewrite it
  always_ff @(posedge CLOCK or negedge EXTERNAL_RESET_PIN) begin
    if (!EXTERNAL_RESET_PIN) begin
      led_en <= `LED_EN_DEF;
      led_fun <= `LED_FUN_DEF;
    end else if (strap_update) begin
      led_en <= soft_led_en;
      led_fun <= soft_led_fun;
    end else if (wr_led) begin
      led_en <= HWDATA[5:0];
      led_fun <= HWDATA[`LED_FUN_LSB+1:`LED_FUN_LSB];
    end
  end

  always_ff @(posedge CLOCK or negedge EXTERNAL_RESET_PIN) begin
    if (!EXTERNAL_RESET_PIN) begin
      phy_bc <= `PHY_BC_RESET_VAL;
      emu_bc <= `EMU_BC_RESET_VAL;
      phy_special <= `SC_RESET_VAL;
    end else begin
      phy_bc <= next_phy_bc;
      emu_bc <= next_emu_bc;
      phy_special <= wr_sc ? HWDATA[2:0] : phy_special;
    end
  end

  // port1 sequencer; a busy reset runs to its end whatever is written
  always_ff @(posedge CLOCK or negedge EXTERNAL_RESET_PIN) begin
    if (!EXTERNAL_RESET_PIN) begin
      phy1_state <= SEQ_IDLE;
      phy1_cnt <= '0;
    end else begin
      unique case (phy1_state)
        SEQ_IDLE: begin
          phy1_cnt <= '0;
          if (phy1_go) begin
            phy1_state <= SEQ_BUSY;
          end
        end
        SEQ_BUSY: begin
          phy1_cnt <= phy1_cnt + CW'(1);
          if (phy1_cnt == PHY1_LAST) begin
            phy1_state <= SEQ_IDLE;
          end
        end
      endcase
    end
  end

  // emulated phy sequencer
  always_ff @(posedge CLOCK or negedge EXTERNAL_RESET_PIN) begin
    if (!EXTERNAL_RESET_PIN) begin
      emu_state <= SEQ_IDLE;
      emu_cnt <= '0;
    end else begin
      unique case (emu_state)
        SEQ_IDLE: begin
          emu_cnt <= '0;
          if (emu_go) begin
            emu_state <= SEQ_BUSY;
          end
        end
        SEQ_BUSY: begin
          emu_cnt <= emu_cnt + CW'(1);
          if (emu_cnt == EMU_LAST) begin
            emu_state <= SEQ_IDLE;
          end
        end
      endcase
    end
  end

  // registered outputs
  always_ff @(posedge CLOCK or negedge EXTERNAL_RESET_PIN) begin
    if (!EXTERNAL_RESET_PIN) begin
      PHY1_RESET <= 1'b0;
      EMU_PHY_RESET <= 1'b0;
      PHY1_POWER_DOWN <= 1'b0;
      PHY1_AN_EN <= 1'b0;
      PHY1_SPEED_LSB <= 1'b0;
      PHY1_DUPLEX <= 1'b0;
      MDIX_AUTO <= 1'b0;
      MDIX_CROSS <= 1'b0;
      LED_EN <= `LED_EN_DEF;
      LED_FUN <= `LED_FUN_DEF;
      DIGITAL_RESET <= 1'b0;
      EE_RELOAD <= 1'b0;
    end else begin
      PHY1_RESET <= phy1_go | (phy1_busy & (phy1_cnt != PHY1_LAST));
      EMU_PHY_RESET <= emu_go | (emu_busy & (emu_cnt != EMU_LAST));
      PHY1_POWER_DOWN <= next_phy_bc[`BC_PDOWN];
      PHY1_AN_EN <= next_phy_bc[`BC_AN];
      PHY1_SPEED_LSB <= next_phy_bc[`BC_SPEED];
      PHY1_DUPLEX <= next_phy_bc[`BC_DUPLEX];
      MDIX_AUTO <= next_mdix_auto;
      MDIX_CROSS <= next_mdix_cross;
      LED_EN <= led_en;
      LED_FUN <= led_fun;
      DIGITAL_RESET <= dig_go;
      EE_RELOAD <= reload_go;
    end
  end

endmodule // phy_reset_and_strap_latch

// ==== phy_reset_defs.svh ====
// offsets, bit positions, reset values and timing figures of the phy reset block
`ifndef PHY_RESET_DEFS_SVH
`define PHY_RESET_DEFS_SVH
`define CLK_PERIOD_NS 50
`define PORT1_PHY_RESET_REQ_TIME_NS 110000
`define EMU_RST_TIME_NS 1000
`define SYNC_SETTLE 2'h3
`define A_RESET_CTRL 8'h00
`define A_PHY_BASIC 8'h04
`define A_EMU_BASIC 8'h08
`define A_HARDWARE_CONFIG_REG 8'h0C
`define A_LED_CONFIG_REG 8'h10
`define A_EE_CMD 8'h14
`define A_PHY_SPECIAL 8'h18
`define RC_DIGITAL 0
`define RC_PHY1 1
`define RC_EMU 3
`define BC_RESET 15
`define BC_SPEED 13
`define BC_AN 12
`define BC_PDOWN 11
`define BC_DUPLEX 8
`define PHY_STICKY_MASK 15'h0400
`define PHY_BC_RESET_VAL 15'h0000
`define EMU_BC_RESET_VAL 15'h3100
`define HW_HARD 0
`define HW_AMDIX1 25
`define HW_READY 27
`define LED_FUN_LSB 8
`define LED_EN_DEF 6'h3F
`define LED_FUN_DEF 2'h0
`define AUTONEG_DEF 1'b1
`define EE_RELOAD_BIT 0
`define SC_STRAP_SEL 0
`define SC_AUTO 1
`define SC_CROSS 2
`define SC_RESET_VAL 3'h1
`endif

// ==== phy_reset_pkg.sv ====
// types shared by the phy reset and strap latch block
package phy_reset_pkg;
  typedef enum logic [1:0] {RK_FULL, RK_SOFT, RK_KEEP} rst_kind_t;
  typedef enum logic {SEQ_IDLE, SEQ_BUSY} seq_state_t;
endpackage

// ==== phy_reset_checker_assertions.sv ====
// assertions on the ports of the phy reset and strap latch block
`timescale 1ns/10ps
module phy_reset_checker #(
  parameter int PORT1_PHY_RESET_REQ_CYCLES = 2200,
  parameter int EMU_RST_CYCLES = 20
) (
  input wire logic CLOCK,
  input wire logic EXTERNAL_RESET_PIN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic EE_PRESENT,
  input wire logic EE_LOAD,
  input wire logic [5:0] EE_LED_EN,
  input wire logic PHY1_RESET,
  input wire logic EMU_PHY_RESET,
  input wire logic [5:0] LED_EN,
  input wire logic DIGITAL_RESET,
  input wire logic EE_RELOAD
);
  logic [11:0] cnt_p, cnt_e;
  logic [2:0] age;
  logic dp_wr;
  logic [7:0] dp_a;
  wire taken = HSEL & HTRANS[1] & HREADY;
  wire wr_rc = dp_wr && dp_a == 8'h00;
  wire wr_bc = dp_wr && dp_a == 8'h04;
  wire wr_eb = dp_wr && dp_a == 8'h08;
  // counters stand in for repetitions far too long to unroll
  always_ff @(posedge CLOCK or negedge EXTERNAL_RESET_PIN) begin
    if (!EXTERNAL_RESET_PIN) begin
      {cnt_p, cnt_e, age, dp_wr, dp_a} <= '0;
    end else begin
      cnt_p <= PHY1_RESET ? cnt_p + 12'h1 : 12'h0;
      cnt_e <= EMU_PHY_RESET ? cnt_e + 12'h1 : 12'h0;
      age <= age + {2'h0, age != 3'h7};
      dp_wr <= taken & HWRITE;
      dp_a <= HADDR[7:0];
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!EXTERNAL_RESET_PIN);
  property p_p1_len; $fell(PHY1_RESET) |-> int'(cnt_p) == PORT1_PHY_RESET_REQ_CYCLES; endproperty
  property p_p1_max; int'(cnt_p) <= PORT1_PHY_RESET_REQ_CYCLES; endproperty
  property p_em_len; $fell(EMU_PHY_RESET) |-> int'(cnt_e) == EMU_RST_CYCLES; endproperty
  property p_p1_go; !PHY1_RESET && (wr_rc && HWDATA[1] || wr_bc && HWDATA[15]) |=> PHY1_RESET; endproperty
  property p_em_go; !EMU_PHY_RESET && (wr_rc && HWDATA[3] || wr_eb && HWDATA[15]) |=> EMU_PHY_RESET; endproperty
  property p_alone; wr_rc && HWDATA[3:0] == 4'h2 |=> !DIGITAL_RESET && !$rose(EMU_PHY_RESET); endproperty
  property p_dig; wr_rc && HWDATA[0] |=> DIGITAL_RESET ##1 !DIGITAL_RESET; endproperty
  property p_busy; taken && !HWRITE && HADDR[7:0] == 8'h00 |=> HRDATA[1] == $past(PHY1_RESET); endproperty
  // a revert in the same data phase beats the eeprom load
  wire revert_now = dp_wr && HWDATA[0] && (dp_a == 8'h00 || dp_a == 8'h14);
  property p_ee; EE_LOAD && EE_PRESENT && age == 3'h7 && !revert_now
    |-> ##3 LED_EN == $past(EE_LED_EN, 3); endproperty
  property p_bus; age > 3'h1 |-> HREADYOUT && !HRESP; endproperty
  a_p1_len: assert property (p_p1_len) else $error("port1 reset span wrong");
  a_p1_max: assert property (p_p1_max) else $error("port1 reset too long");
  a_em_len: assert property (p_em_len) else $error("emulated reset span wrong");
  a_p1_go: assert property (p_p1_go) else $error("port1 reset not started");
  a_em_go: assert property (p_em_go) else $error("emulated reset not started");
  a_alone: assert property (p_alone) else $error("port1 reset touched others");
  a_dig: assert property (p_dig) else $error("digital reset pulse wrong");
  a_busy: assert property (p_busy) else $error("busy bit mismatch");
  a_ee: assert property (p_ee) else $error("eeprom value not taken");
  a_bus: assert property (p_bus) else $error("bus not ready");
  c_p1: cover property ($fell(PHY1_RESET));
  c_em: cover property ($fell(EMU_PHY_RESET));
  c_ee: cover property (EE_LOAD && EE_PRESENT);
endmodule // phy_reset_checker

bind phy_reset_and_strap_latch phy_reset_checker #(.PORT1_PHY_RESET_REQ_CYCLES(PORT1_PHY_RESET_REQ_CYCLES),
  .EMU_RST_CYCLES(EMU_RST_CYCLES)) u_chk (.*);

// ==== phy_reset_and_strap_latch_tb.sv ====
// self-checking bench for the phy reset and strap latch block
`timescale 1ns/10ps
module phy_reset_and_strap_latch_tb;
  logic CLOCK, EXTERNAL_RESET_PIN, HSEL, HWRITE, HREADYOUT, HRESP, PHY1_RESET, EMU_PHY_RESET, DIGITAL_RESET, EE_RELOAD;
  logic STRAP_AUTO_MDIX, STRAP_MANUAL_MDIX, STRAP_HARD, EE_PRESENT, EE_LOAD, EE_AUTO_MDIX, EE_MANUAL_MDIX;
  logic EE_AUTONEG, PHY1_POWER_DOWN, PHY1_AN_EN, PHY1_SPEED_LSB, PHY1_DUPLEX, MDIX_AUTO, MDIX_CROSS;
  logic [31:0] HADDR, HWDATA, HRDATA, r;
  logic [1:0] HTRANS, EE_LED_FUN, LED_FUN;
  logic [2:0] HSIZE;
  logic [5:0] EE_LED_EN, LED_EN;
  wire HREADY = HREADYOUT;
  int bad_count, samples_checked, seed, m_auto, m_man, m_hard, n;
  phy_reset_and_strap_latch #(.PORT1_PHY_RESET_REQ_CYCLES(8), .EMU_RST_CYCLES(3)) u_dut (.*);
  initial begin
    CLOCK = 1'b0;
    forever #25 CLOCK = ~CLOCK;
  end
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  // waits end only through the watchdog
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    HADDR <= {24'h0, a};
    HWRITE <= w;
    HTRANS <= 2'h2;
    do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
    r = HRDATA;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string s);
    bus(a, 1'b0, 32'h0);
    chk(s, e, r);
    chk("hresp", 0, HRESP);
  endtask
  task automatic poll(input logic [7:0] a, input int b, input int lim);
    bus(a, 1'b0, 32'h0);
    chk("busy bit", 1, r[b]);
    n = 0;
    while (r[b] === 1'b1) begin
      bus(a, 1'b0, 32'h0);
      n++;
    end
    chk("busy span", 1, n <= lim);
  endtask
  function automatic logic [31:0] hw(input int a);
    return 32'h0800_0000 | a << 25 | m_hard;
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    bad_count++;
    wrap_up();
  end
  initial begin
    seed = 75;
    {HSEL, HSIZE, HTRANS, HWRITE, HADDR, HWDATA} = {1'b1, 3'h2, 67'h0};
    {EE_PRESENT, EE_LOAD, EE_LED_EN, EE_LED_FUN, EE_AUTO_MDIX, EE_MANUAL_MDIX, EE_AUTONEG} = 13'h0;
    {STRAP_AUTO_MDIX, STRAP_MANUAL_MDIX, STRAP_HARD} = 3'($random(seed));
    EXTERNAL_RESET_PIN = 1'b0;
    repeat (8) @(posedge CLOCK);
    EXTERNAL_RESET_PIN <= 1'b1;
    m_auto = STRAP_AUTO_MDIX;
    m_man = STRAP_MANUAL_MDIX;
    m_hard = STRAP_HARD;
    repeat (8) @(posedge CLOCK);
    rd(8'h0C, hw(m_auto), "hardware_config_reg");
    {STRAP_AUTO_MDIX, STRAP_MANUAL_MDIX, STRAP_HARD} <= ~{STRAP_AUTO_MDIX, STRAP_MANUAL_MDIX, STRAP_HARD};
    rd(8'h10, 32'h3F, "led_config_reg");
    rd(8'h04, 32'h3000, "basic ctrl");
    rd(8'h08, 32'h3100, "emu ctrl");
    chk("mdix auto", m_auto, MDIX_AUTO);
    chk("mdix cross", !m_auto && m_man, MDIX_CROSS);
    bus(8'h20, 1'b1, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0, "unmapped");
    $display("done defaults");
    bus(8'h04, 1'b1, 32'h3400);
    bus(8'h00, 1'b1, 32'h2);
    bus(8'h00, 1'b1, 32'h0);
    chk("emu quiet", 0, EMU_PHY_RESET);
    chk("port1 busy", 1, PHY1_RESET);
    poll(8'h00, 1, 6);
    rd(8'h04, 32'h3000, "full reinit");
    bus(8'h04, 1'b1, 32'h3500);
    bus(8'h04, 1'b1, 32'hB500);
    poll(8'h04, 15, 6);
    rd(8'h04, 32'h3400, "sticky kept");
    rd(8'h00, 32'h0, "rc clear");
    bus(8'h04, 1'b1, 32'h3C04);
    @(posedge CLOCK);
    chk("power down", 1, PHY1_POWER_DOWN);
    bus(8'h04, 1'b1, 32'h3404);
    poll(8'h00, 1, 6);
    rd(8'h04, 32'h3404, "wake keeps regs");
    chk("phy pins", 4'h6, {PHY1_POWER_DOWN, PHY1_AN_EN, PHY1_SPEED_LSB, PHY1_DUPLEX});
    $display("done port1");
    for (int k = 0; k < 2; k++) begin
      bus(8'h08, 1'b1, 32'h1234);
      bus(k ? 8'h08 : 8'h00, 1'b1, k ? 32'h9234 : 32'h8);
      poll(k ? 8'h08 : 8'h00, k ? 15 : 3, 3);
      rd(8'h08, 32'h3100, "emu reinit");
    end
    $display("done emulated");
    for (int k = 0; k < 2; k++) begin
      {EE_LED_EN, EE_LED_FUN, EE_AUTO_MDIX, EE_MANUAL_MDIX, EE_AUTONEG} <= 11'($random(seed));
      EE_PRESENT <= 1'b1;
      EE_LOAD <= 1'b1;
      @(posedge CLOCK);
      EE_LOAD <= 1'b0;
      repeat (3) @(posedge CLOCK);
      chk("ee led", {EE_LED_FUN, 2'h0, EE_LED_EN}, {LED_FUN, 2'h0, LED_EN});
      chk("ee an", EE_AUTONEG, PHY1_AN_EN);
      chk("ee duplex", !EE_AUTONEG, PHY1_DUPLEX);
      rd(8'h0C, hw(EE_AUTO_MDIX), "hard kept");
      EE_PRESENT <= 1'b0;
      bus(k ? 8'h14 : 8'h00, 1'b1, 32'h1);
      repeat (3) @(posedge CLOCK);
      chk("revert led", 32'h3F, LED_EN);
      chk("revert an", 1, PHY1_AN_EN);
      rd(8'h0C, hw(m_auto), "no resample");
    end
    $display("done straps");
    EXTERNAL_RESET_PIN <= 1'b0;
    repeat (3) @(posedge CLOCK);
    EXTERNAL_RESET_PIN <= 1'b1;
    m_auto = STRAP_AUTO_MDIX;
    m_hard = STRAP_HARD;
    m_man = STRAP_MANUAL_MDIX;
    repeat (8) @(posedge CLOCK);
    rd(8'h0C, hw(m_auto), "resampled");
    chk("mdix cross again", !m_auto && m_man, MDIX_CROSS);
    $display("done rereset");
    wrap_up();
  end
endmodule // phy_reset_and_strap_latch_tb
